// ===== verilog/esa_pkg.sv
// Constants shared by the parameter-channel resource handler and its level keeper.
// Assumes one clock domain; control, address and offset fields are byte-wide on the parameter channel, the buffer is 64 bits.
package esa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Resource indices and descriptor contents
  localparam logic [9:0] INDEX_PRESET = 10'h101;
  localparam logic [9:0] INDEX_ACCESS = 10'h104;
  localparam logic [7:0] DATA_SIZE = 8'h08;
  localparam logic [7:0] PRESET_RD_LEVEL = 8'h00;
  localparam logic [7:0] PRESET_WR_LEVEL = 8'h04;
  localparam logic [7:0] ACCESS_RD_LEVEL = 8'h00;
  localparam logic [7:0] ACCESS_WR_LEVEL = 8'h00;
  localparam logic [7:0] TYPE_U64 = 8'h06;
  localparam logic [7:0] TYPE_STRUCT8 = 8'h18;
  // Names, first character in byte 0
  localparam logic [63:0] NAME_PRESET = 64'h0000_534f_5054_4553;
  localparam logic [63:0] NAME_ACCESS = 64'h5345_4343_4154_4553;

  // Descriptor offsets
  localparam logic [15:0] DESC_NAME = 16'h0000;
  localparam logic [15:0] DESC_SIZE = 16'h0001;
  localparam logic [15:0] DESC_RD_LEVEL = 16'h0002;
  localparam logic [15:0] DESC_WR_LEVEL = 16'h0003;
  localparam logic [15:0] DESC_OVERRUN = 16'h0004;
  localparam logic [15:0] DESC_TYPE = 16'h0005;

  ////////////////////////////////////////////////////////////////////////////
  // Address high byte fields, transfer control start bit and position width
  localparam int ADDR_READ_BIT = 6;
  localparam int ADDR_DIRECT_BIT = 5;
  localparam int CTRL_START_BIT = 0;
  localparam int POS_WIDTH = 40;

  ////////////////////////////////////////////////////////////////////////////
  // Access levels and standard keys
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [7:0] LEVEL_MAX = 8'h04;
  localparam logic [31:0] KEY_LEVEL1 = 32'h3131_3131;
  localparam logic [31:0] KEY_LEVEL2 = 32'h3232_3232;
  localparam logic [31:0] KEY_LEVEL3 = 32'h3333_3333;
  localparam logic [31:0] KEY_LEVEL4 = 32'h3434_3434;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_RESOURCE = 8'h01;
  localparam logic [7:0] ERR_DENIED = 8'h02;
  localparam logic [7:0] ERR_RANGE = 8'h03;
  localparam logic [7:0] ERR_KEY = 8'h04;
  localparam logic [7:0] ERR_UNSUPPORTED = 8'h05;

endpackage

// ===== verilog/esa_acc_if.sv
// Link between the transaction handler and the access level keeper.
// Assumes both ends run on the same clock.
interface esa_acc_if;
  logic wr_req;
  logic [7:0] req_level;
  logic [31:0] req_key;
  logic [2:0] level;
  logic done;
  logic refused;

  modport handler (output wr_req, output req_level, output req_key, input level, input done, input refused);
  modport keeper (input wr_req, input req_level, input req_key, output level, output done, output refused);
endinterface

// ===== verilog/esa_level_keeper.sv
// Current access level and the key store behind it.
// Assumes wr_req is a one-cycle pulse from the handler on the same clock.
module esa_level_keeper (
  input wire logic i_clk,
  input wire logic i_rst_b,
  esa_acc_if.keeper acc
);

  logic [31:0] key [0:4];
  logic key_ok;
  logic level_ok;

  // Key slot 0 is never compared: level 0 is public
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      key[0] <= 32'h0000_0000;
      key[1] <= esa_pkg::KEY_LEVEL1;
      key[2] <= esa_pkg::KEY_LEVEL2;
      key[3] <= esa_pkg::KEY_LEVEL3;
      key[4] <= esa_pkg::KEY_LEVEL4;
    end
  end

  always_comb begin
    level_ok = acc.req_level <= esa_pkg::LEVEL_MAX; // RL19
    key_ok = (acc.req_level[2:0] == 3'h0) || (level_ok && acc.req_key == key[acc.req_level[2:0]]); // RL10 RL12
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc.level <= esa_pkg::LEVEL_RESET; // RL9
    end else if (acc.wr_req && level_ok && key_ok) begin
      acc.level <= acc.req_level[2:0]; // RL11
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc.done <= 1'b0;
      acc.refused <= 1'b0;
    end else begin
      acc.done <= acc.wr_req;
      acc.refused <= acc.wr_req && !(level_ok && key_ok); // RL19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_level_at_reset: assert property (@(posedge i_clk) !i_rst_b |-> acc.level == 3'h0) // RL9
    else $error("access level not zero during reset");
  a_level_held: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL11
    !acc.wr_req |=> $stable(acc.level))
    else $error("access level changed without a write");
  a_wrong_key: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL10
    acc.wr_req && acc.req_level >= 8'h01 && acc.req_level <= 8'h04 && acc.req_key != key[acc.req_level[2:0]]
    |=> acc.refused && $stable(acc.level))
    else $error("level changed with a wrong key");
  a_default_key: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL12
    acc.wr_req && acc.req_level == 8'h02 && acc.req_key == 32'h3232_3232 |=> acc.level == 3'h2 && !acc.refused)
    else $error("standard key for level 2 not accepted");
  a_level_limit: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL19
    acc.wr_req && acc.req_level > 8'h04 |=> acc.refused && acc.done ##1 !acc.done)
    else $error("level above four not refused");

endmodule

// ===== verilog/esa_param_handler.sv
// Encoder-side handler for the shaft position preset and access level resources.
// Assumes request fields come from logic on the same clock and are stable with i_start;
// the raw shaft position is also on this clock.

////////////////////////////////////////////////////////////////////////////
// How it works
// RL1 - Preset descriptor: 101h, size 8, levels 0/4
// RL2 - Preset write makes value the current position
// RL3 - Presets outside measurement range are invalid
// RL4 - Preset read returns offset, 40-bit right-justified
// RL5 - Controller puts position in bytes 4..0
// RL6 - Controller presets only with stationary shaft
// RL7 - Preset write: 1D/01, offsets 00, control 01
// RL8 - Access descriptor: 104h, size 8, levels 0/0
// RL9 - Access level zero after every reset
// RL10 - Level changes only with its matching key
// RL11 - Level held until next successful write
// RL12 - Five levels; default keys 31..34 repeated
// RL13 - Controller: key bytes 7..4, level byte 0
// RL14 - Level read returns level in byte 0
// RL15 - Controller leaves offset unused for access level
// RL16 - Level write: 1D/04, offsets 00, control 01
// RL17 - Level read: 55/04, offsets 00, control 01
// RL18 - Preset refused below write level four
// RL19 - Refuse wrong key or level above four
module esa_param_handler #(
  parameter int POS_RANGE_BITS = 40,
  parameter logic [7:0] TIME_OVERRUN = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic [7:0] i_param_transfer_control,
  input wire logic [7:0] i_param_address_high,
  input wire logic [7:0] i_param_address_low,
  input wire logic [7:0] i_param_offset_high,
  input wire logic [7:0] i_param_offset_low,
  input wire logic [63:0] i_param_buffer,
  input wire logic [39:0] i_shaft_position,
  output logic o_function_release_flag,
  output logic [63:0] o_param_buffer,
  output logic [7:0] o_error_code,
  output logic [2:0] o_access_level,
  output logic [39:0] o_position_offset,
  output logic [39:0] o_position
);

  typedef enum logic [1:0] {
    ESA_IDLE,
    ESA_EXEC,
    ESA_SETTLE
  } esa_state_e;

  if (POS_RANGE_BITS < 1 || POS_RANGE_BITS > esa_pkg::POS_WIDTH) begin : g_bad_range
    $error("POS_RANGE_BITS must lie between 1 and 40");
  end

  localparam logic [39:0] RANGE_MASK = 40'hff_ffff_ffff >> (esa_pkg::POS_WIDTH - POS_RANGE_BITS);

  // Wrap into the measurement range
  function automatic logic [39:0] esa_wrap(input logic [39:0] value);
    return value & RANGE_MASK;
  endfunction

  esa_acc_if acc ();

  esa_state_e state;
  logic take;
  logic [7:0] req_addr_high;
  logic [7:0] req_addr_low;
  logic [15:0] req_offset;
  logic [63:0] req_buffer;
  logic [9:0] req_index;
  logic req_read;
  logic req_direct;
  logic preset_wr;
  logic preset_ok;
  logic level_wr;
  logic [63:0] next_buffer;
  logic [7:0] next_error;

  ////////////////////////////////////////////////////////////////////////////
  // Request capture and sequencing
  assign take = o_function_release_flag && i_start && i_param_transfer_control[esa_pkg::CTRL_START_BIT];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_addr_high <= 8'h00;
      req_addr_low <= 8'h00;
      req_offset <= 16'h0000;
      req_buffer <= 64'h0;
    end else if (take) begin
      req_addr_high <= i_param_address_high;
      req_addr_low <= i_param_address_low;
      req_offset <= {i_param_offset_high, i_param_offset_low};
      req_buffer <= i_param_buffer;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ESA_IDLE;
    end else begin
      unique case (state)
        ESA_IDLE: begin
          if (take) begin
            state <= ESA_EXEC;
          end
        end
        ESA_EXEC: begin
          state <= ESA_SETTLE;
        end
        ESA_SETTLE: begin
          state <= ESA_IDLE;
        end
        default: begin
          state <= ESA_IDLE;
        end
      endcase
    end
  end

  // Release drops on acceptance and rises when the answer stands
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_function_release_flag <= 1'b1;
    end else if (take) begin
      o_function_release_flag <= 1'b0;
    end else if (state == ESA_SETTLE) begin
      o_function_release_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode and answer
  assign req_index = {req_addr_high[1:0], req_addr_low};
  assign req_read = req_addr_high[esa_pkg::ADDR_READ_BIT];
  assign req_direct = req_addr_high[esa_pkg::ADDR_DIRECT_BIT];
  assign preset_wr = state == ESA_EXEC && !req_direct && !req_read && req_index == esa_pkg::INDEX_PRESET;
  // Bits above the range, including bytes 5..7, make the preset invalid
  assign preset_ok = preset_wr && {5'h00, o_access_level} >= esa_pkg::PRESET_WR_LEVEL // RL18
    && req_buffer[63:40] == 24'h0 && (req_buffer[39:0] & ~RANGE_MASK) == 40'h0; // RL3 RL5
  assign level_wr = state == ESA_EXEC && !req_direct && !req_read && req_index == esa_pkg::INDEX_ACCESS;

  // Level write goes to the keeper; offset bytes are ignored here
  assign acc.wr_req = level_wr; // RL15
  assign acc.req_level = req_buffer[7:0]; // RL13
  assign acc.req_key = req_buffer[63:32];
  assign o_access_level = acc.level;

  always_comb begin
    next_buffer = 64'h0;
    next_error = esa_pkg::ERR_NONE;
    if (req_direct) begin
      if (!req_read) begin
        next_error = esa_pkg::ERR_UNSUPPORTED;
      end else if (req_index == esa_pkg::INDEX_PRESET || req_index == esa_pkg::INDEX_ACCESS) begin
        unique case (req_offset)
          esa_pkg::DESC_NAME: begin
            next_buffer = req_index == esa_pkg::INDEX_PRESET ? esa_pkg::NAME_PRESET : esa_pkg::NAME_ACCESS;
          end
          esa_pkg::DESC_SIZE: begin
            next_buffer[7:0] = esa_pkg::DATA_SIZE; // RL1 RL8
          end
          esa_pkg::DESC_RD_LEVEL: begin
            next_buffer[7:0] = req_index == esa_pkg::INDEX_PRESET ? esa_pkg::PRESET_RD_LEVEL
              : esa_pkg::ACCESS_RD_LEVEL;
          end
          esa_pkg::DESC_WR_LEVEL: begin
            next_buffer[7:0] = req_index == esa_pkg::INDEX_PRESET ? esa_pkg::PRESET_WR_LEVEL // RL1
              : esa_pkg::ACCESS_WR_LEVEL; // RL8
          end
          esa_pkg::DESC_OVERRUN: begin
            next_buffer[7:0] = TIME_OVERRUN;
          end
          esa_pkg::DESC_TYPE: begin
            next_buffer[7:0] = req_index == esa_pkg::INDEX_PRESET ? esa_pkg::TYPE_U64 : esa_pkg::TYPE_STRUCT8;
          end
          default: begin
            next_error = esa_pkg::ERR_RESOURCE;
          end
        endcase
      end else begin
        next_error = esa_pkg::ERR_RESOURCE;
      end
    end else if (req_index == esa_pkg::INDEX_PRESET) begin
      if (req_read) begin
        next_buffer = {24'h0, o_position_offset}; // RL4
      end else if ({5'h00, o_access_level} < esa_pkg::PRESET_WR_LEVEL) begin
        next_error = esa_pkg::ERR_DENIED; // RL18
      end else if (!preset_ok) begin
        next_error = esa_pkg::ERR_RANGE; // RL3
      end
    end else if (req_index == esa_pkg::INDEX_ACCESS) begin
      if (req_read) begin
        next_buffer = {61'h0, o_access_level}; // RL14
      end
    end else begin
      next_error = esa_pkg::ERR_RESOURCE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_param_buffer <= 64'h0;
      o_error_code <= esa_pkg::ERR_NONE;
    end else if (state == ESA_EXEC) begin
      o_param_buffer <= next_buffer;
      o_error_code <= next_error;
    end else if (state == ESA_SETTLE && acc.done && acc.refused) begin
      o_error_code <= esa_pkg::ERR_KEY; // RL19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position offset
  // No synchronisation with motion: the raw sample of this cycle is used as is
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_position_offset <= 40'h0;
    end else if (preset_ok) begin
      o_position_offset <= esa_wrap(40'(req_buffer[39:0] - i_shaft_position)); // RL2
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_position <= 40'h0;
    end else begin
      o_position <= esa_wrap(40'(i_shaft_position + o_position_offset)); // RL2
    end
  end

  esa_level_keeper u_keeper (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .acc(acc.keeper)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_release_timing: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take |=> !o_function_release_flag ##1 !o_function_release_flag ##1 o_function_release_flag)
    else $error("release flag timing wrong");
  a_preset_applied: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL2
    preset_ok ##1 $stable(i_shaft_position) |=> o_position == esa_wrap($past(req_buffer[39:0], 2)))
    else $error("preset value not reported as position");
  a_preset_range: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL3
    preset_wr && (req_buffer[39:0] & ~RANGE_MASK) != 40'h0 |=> $stable(o_position_offset)
      && o_error_code != esa_pkg::ERR_NONE)
    else $error("out of range preset accepted");
  a_offset_read: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL4
    state == ESA_EXEC && !req_direct && req_read && req_index == 10'h101
      |=> o_param_buffer == {24'h0, $past(o_position_offset)})
    else $error("offset read back wrong");
  a_preset_desc: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL1
    state == ESA_EXEC && req_direct && req_read && req_index == 10'h101 && req_offset == 16'h0003
      |=> o_param_buffer == 64'h4 && o_error_code == 8'h00)
    else $error("preset write level descriptor wrong");
  a_access_desc: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL8
    state == ESA_EXEC && req_direct && req_read && req_index == 10'h104 && req_offset == 16'h0005
      |=> o_param_buffer == 64'h18)
    else $error("access level data type wrong");
  a_level_read: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL14
    state == ESA_EXEC && !req_direct && req_read && req_index == 10'h104
      |=> o_param_buffer[7:0] == {5'h00, o_access_level} ##1 o_function_release_flag)
    else $error("level read answer wrong");
  a_preset_denied: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL18
    preset_wr && o_access_level < 3'h4 |=> $stable(o_position_offset) && o_error_code == 8'h02)
    else $error("preset accepted below level four");
  a_key_error: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL19
    level_wr && req_buffer[7:0] > 8'h04 |=> ##1 o_error_code == 8'h04 && o_function_release_flag)
    else $error("bad level write not reported");

endmodule

// ===== testbench/esa_master_model.sv
// Far-side controller model: issues one parameter-channel transaction at a time.
// Assumes the handler drops and then raises the release flag for each request it takes.
module esa_master_model (
  input wire logic i_clk,
  input wire logic i_release,
  output logic o_start,
  output logic [7:0] o_ctrl,
  output logic [7:0] o_addr_high,
  output logic [7:0] o_addr_low,
  output logic [7:0] o_off_high,
  output logic [7:0] o_off_low,
  output logic [63:0] o_buffer
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_start = 1'b0;
    o_ctrl = 8'h00;
    o_addr_high = 8'h00;
    o_addr_low = 8'h00;
    o_off_high = 8'h00;
    o_off_low = 8'h00;
    o_buffer = 64'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fields held until release returns, then inverted except the offset bytes, which keep their values
  task automatic xfer(input logic [7:0] ah, input logic [7:0] al, input logic [15:0] off,
                      input logic [63:0] data, input logic [7:0] ctrl, output logic seen);
    int n;
    n = 0;
    seen = 1'b0;
    while (i_release !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    o_start = 1'b1;
    o_ctrl = ctrl;
    o_addr_high = ah;
    o_addr_low = al;
    o_off_high = off[15:8];
    o_off_low = off[7:0];
    o_buffer = data;
    @(negedge i_clk);
    o_start = 1'b0;
    n = 0;
    while (!(seen && i_release === 1'b1) && n < 20) begin
      if (i_release === 1'b0) begin
        seen = 1'b1;
      end
      @(negedge i_clk);
      n++;
    end
    o_ctrl = ~o_ctrl;
    o_addr_high = ~o_addr_high;
    o_addr_low = ~o_addr_low;
    o_buffer = ~o_buffer;
  endtask
endmodule

// ===== testbench/encoder_shaft_position_preset_access_level_test.sv
// Self-checking bench for the preset and access level handler.
// Assumes the far-side model drives all request fields; shaft position is driven here.
module encoder_shaft_position_preset_access_level_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_b, start, release_flag, seen;
  logic [7:0] ctrl, ah, al, oh, ol, err;
  logic [63:0] wbuf, pbuf;
  logic [39:0] shaft, offs, pos;
  logic [2:0] lvl;
  int error_cnt = 0;
  int tests_run = 0;
  logic [63:0] dexp [2][6];
  logic [9:0] res_index [2];

  // Narrow range so out-of-range presets are reachable
  esa_param_handler #(.POS_RANGE_BITS(16)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_start(start),
    .i_param_transfer_control(ctrl), .i_param_address_high(ah), .i_param_address_low(al),
    .i_param_offset_high(oh), .i_param_offset_low(ol), .i_param_buffer(wbuf), .i_shaft_position(shaft),
    .o_function_release_flag(release_flag), .o_param_buffer(pbuf), .o_error_code(err),
    .o_access_level(lvl), .o_position_offset(offs), .o_position(pos));

  esa_master_model master (.i_clk(clk), .i_release(release_flag), .o_start(start), .o_ctrl(ctrl),
    .o_addr_high(ah), .o_addr_low(al), .o_off_high(oh), .o_off_low(ol), .o_buffer(wbuf));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic go(input logic [7:0] a_hi, input logic [7:0] a_lo, input logic [63:0] data);
    master.xfer(a_hi, a_lo, 16'h0, data, 8'h01, seen);
    chk("answered", {63'h0, seen}, 64'h1);
  endtask

  task automatic set_level(input logic [7:0] lv, input logic [31:0] key, input logic [7:0] e_err,
                           input logic [2:0] e_lvl);
    go(8'h1d, 8'h04, {key, 24'h0, lv});
    chk("level error", {56'h0, err}, {56'h0, e_err});
    chk("level", {61'h0, lvl}, {61'h0, e_lvl});
    go(8'h55, 8'h04, 64'h0);
    chk("level read", pbuf, {61'h0, e_lvl});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state;
    chk("release idle", {63'h0, release_flag}, 64'h1);
    chk("reset level", {61'h0, lvl}, 64'h0);
    master.xfer(8'h55, 8'h04, 16'h0, 64'h0, 8'h00, seen);
    chk("control bit clear ignored", {63'h0, seen}, 64'h0);
    $display("test reset_state done");
  endtask

  task automatic t_descriptors;
    for (int r = 0; r < 2; r++) begin
      for (int o = 0; o < 6; o++) begin
        master.xfer({6'b011000, res_index[r][9:8]}, res_index[r][7:0], o[15:0], 64'h0, 8'h01, seen);
        chk("descriptor", pbuf, dexp[r][o]);
      end
    end
    $display("test descriptors done");
  endtask

  task automatic t_levels;
    logic [7:0] b;
    for (int l = 1; l < 5; l++) begin
      b = 8'h30 + l[7:0];
      set_level(l[7:0], {4{b}} ^ 32'h0100_0000, 8'h04, l[2:0] - 3'h1);
      set_level(l[7:0], {4{b}}, 8'h00, l[2:0]);
      if (l < 4) begin
        go(8'h1d, 8'h01, 64'h5);
        chk("preset denied", {56'h0, err}, 64'h2);
        chk("offset kept", {24'h0, offs}, 64'h0);
      end
    end
    set_level(8'h05, 32'h3535_3535, 8'h04, 3'h4);
    set_level(8'h02, 32'h3434_3434, 8'h04, 3'h4);
    set_level(8'h00, 32'h0000_0000, 8'h00, 3'h0);
    set_level(8'h04, 32'h3434_3434, 8'h00, 3'h4);
    $display("test levels done");
  endtask

  // Shaft held still across each preset; the handler does not synchronise the preset with motion
  task automatic t_preset;
    shaft = 40'h12_0000_1234;
    repeat (2) @(negedge clk);
    go(8'h1d, 8'h01, 64'h0100);
    chk("preset error", {56'h0, err}, 64'h0);
    chk("preset offset", {24'h0, offs}, 64'heecc);
    chk("preset position", {24'h0, pos}, 64'h0100);
    go(8'h55, 8'h01, 64'h0);
    chk("offset read", pbuf, 64'heecc);
    go(8'h1d, 8'h01, 64'h1_0000);
    chk("range error", {56'h0, err}, 64'h3);
    go(8'h1d, 8'h01, 64'h0100_0000_0005);
    chk("high byte error", {56'h0, err}, 64'h3);
    chk("offset after refusal", {24'h0, offs}, 64'heecc);
    shaft = 40'h12_0000_1239;
    repeat (2) @(negedge clk);
    chk("tracked position", {24'h0, pos}, 64'h0105);
    go(8'h1d, 8'h01, 64'hffff);
    chk("top preset offset", {24'h0, offs}, 64'hedc6);
    chk("top preset position", {24'h0, pos}, 64'hffff);
    $display("test preset done");
  endtask

  task automatic t_reset_again;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk("level after reset", {61'h0, lvl}, 64'h0);
    go(8'h55, 8'h04, 64'h0);
    chk("level read after reset", pbuf, 64'h0);
    $display("test reset_again done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    error_cnt++;
    $display("watchdog expired");
    test_done;
  end

  initial begin
    res_index = '{10'h101, 10'h104};
    dexp = '{'{esa_pkg::NAME_PRESET, 64'h8, 64'h0, 64'h4, 64'h0, 64'h6},
             '{esa_pkg::NAME_ACCESS, 64'h8, 64'h0, 64'h0, 64'h0, 64'h18}};
    clk = 1'b0;
    rst_b = 1'b0;
    shaft = 40'h0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset_state;
    t_descriptors;
    t_levels;
    t_preset;
    t_reset_again;
    test_done;
  end
endmodule
